// File: tdm_stream_test.sv
// stream test patterns, bit error checkers, law translation, quadrant forcing
// assumes channel bytes arrive one per cycle tagged with stream and channel,
// and a synchronous host port with one-cycle read and write strobes
`timescale 1ns/10ps
// Function
// RULE_01: pattern generator and checker per stream
// RULE_02: generators produce 2^15-1 pseudo-random sequence
// RULE_03: pattern may cover any channels, up to frame
// RULE_04: mode bits 5/4 enable groups, reset off
// RULE_05: software routes pattern over consecutive channels
// RULE_06: control bit 1 clears count, bit 0 enables
// RULE_07: 8-bit start channel per stream
// RULE_08: 9-bit channel length per stream
// RULE_09: software keeps window inside stream channels
// RULE_10: 16-bit error count saturates at all ones
// RULE_11: software marks pattern channels in connection word
// RULE_12: software waits two frames before enabling checker
// RULE_13: translation for switched and message channels
// RULE_14: class bit, input law, output law fields
// RULE_15: voice law codes a, mu and variants
// RULE_16: mu variant leaves magnitude bits uninverted
// RULE_17: data codes invert none, even, odd, all
// RULE_18: differing laws convert, equal laws pass
// RULE_19: input frame split into four quadrants
// RULE_20: four 3-bit quadrant codes per stream
// RULE_21: codes force lsb or msb to value
// RULE_22: software avoids forcing with checker together
// RULE_23: compare only window channels, count each bit
module tdm_stream_test #(
  parameter int N = tdm_xlate_pkg::NUM_STREAMS
) (
  // clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_sys_rst,
  // host port
  input  wire logic                     i_cs,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  input  wire logic [13:0]              i_addr,
  input  wire logic [15:0]              i_wdata,
  output logic      [15:0]              o_rdata,
  output logic                          o_rd_valid,
  // input stream channels
  input  wire logic                     i_rx_valid,
  input  wire tdm_xlate_pkg::rx_chan_t  i_rx,
  output logic                          o_rx_valid,
  output logic      [7:0]               o_rx_byte,
  // output stream channels
  input  wire logic                     i_tx_valid,
  input  wire tdm_xlate_pkg::tx_chan_t  i_tx,
  output logic                          o_tx_valid,
  output logic      [7:0]               o_tx_byte
);
  import tdm_xlate_pkg::*;
  localparam int SW = $clog2(N);

  // 8 bits of the sequence: checks rx bits, or produces them when gen set
  function automatic logic [26:0] prbs8(input logic [14:0] h, input logic [7:0] d,
                                        input logic gen);
    logic [7:0] b;
    logic [3:0] e;
    logic       x;
    b = d;
    e = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      x = h[13] ^ h[14];
      if (gen) b[i] = x;
      e = e + 4'(x != b[i]);
      h = {h[13:0], b[i]};
    end
    prbs8 = {b, e, h};
  endfunction

  // ********************
  // host registers
  // ********************
  logic             chk_grp_en;
  logic             gen_grp_en;
  logic [N-1:0]     chk_en;
  logic [N-1:0]     cnt_clr;
  logic [7:0]       start_ch [N];
  logic [8:0]       len_ch   [N];
  logic [11:0]      qforce   [N];
  logic [ERR_W-1:0] err_cnt  [N];
  logic             wr_en;
  logic [SW-1:0]    idx;

  assign wr_en = i_cs && i_wr;
  assign idx   = i_addr[SW-1:0];

  // RULE_04 group enables
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      chk_grp_en <= 1'b0;
      gen_grp_en <= 1'b0;
    end else if (wr_en && i_addr == ADDR_MODE) begin
      chk_grp_en <= i_wdata[MODE_CHK_BIT];
      gen_grp_en <= i_wdata[MODE_GEN_BIT];
    end
  end

  // ********************
  // checker pipeline signals
  // ********************
  rx_chan_t    r1;
  logic        r1_valid;
  logic [2:0]  r1_code;
  logic [14:0] rx_hist;
  logic [14:0] rx_rdata;
  logic [26:0] rx_res;
  logic        in_win;
  logic        chk_hit;
  logic [N-1:0] rx_init;
  logic [8:0]  rel;

  always_comb begin
    rx_hist = rx_init[r1.stream] ? rx_rdata : 15'h0000;
    rx_res  = prbs8(rx_hist, r1.data, 1'b0);
    rel     = {1'b0, r1.chan} - {1'b0, start_ch[r1.stream]};
    // RULE_23 window of start..start+len-1
    in_win  = (r1.chan >= start_ch[r1.stream]) && (rel < len_ch[r1.stream]);
    chk_hit = r1_valid && chk_grp_en && chk_en[r1.stream] && in_win;
  end

  for (genvar n = 0; n < N; n++) begin : g_stream
    logic         sel;
    logic [16:0]  sum;
    logic [3:0]   inc;
    assign sel = (idx == SW'(n));
    assign inc = (chk_hit && r1.stream == 5'(n)) ? rx_res[18:15] : 4'h0;
    assign sum = {1'b0, err_cnt[n]} + 17'(inc);
    // RULE_06 clear strobe
    assign cnt_clr[n] = wr_en && sel && i_addr[13:SW] == ADDR_CTRL_BASE[13:SW]
                        && i_wdata[CTRL_CLR_BIT];

    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        chk_en[n]   <= 1'b0;
        start_ch[n] <= 8'h00;
        len_ch[n]   <= 9'h000;
        qforce[n]   <= 12'h000;
      end else if (wr_en && sel) begin
        // RULE_06 per-stream enable
        if (i_addr[13:SW] == ADDR_CTRL_BASE[13:SW]) chk_en[n] <= i_wdata[CTRL_EN_BIT];
        // RULE_07 start channel
        if (i_addr[13:SW] == ADDR_START_BASE[13:SW]) start_ch[n] <= i_wdata[7:0];
        // RULE_08 channel length
        if (i_addr[13:SW] == ADDR_LEN_BASE[13:SW]) len_ch[n] <= i_wdata[8:0];
        // RULE_20 quadrant codes
        if (i_addr[13:SW] == ADDR_QUAD_BASE[13:SW]) qforce[n] <= i_wdata[11:0];
      end
    end

    // RULE_10 saturating count; errors in the clear cycle are kept
    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        err_cnt[n] <= 16'h0000;
      end else if (cnt_clr[n]) begin
        err_cnt[n] <= 16'(inc);
      end else if (sum[16]) begin
        err_cnt[n] <= ERR_MAX;
      end else begin
        err_cnt[n] <= sum[15:0];
      end
    end

    property p_sat;
      @(posedge i_clk) disable iff (i_sys_rst)
      err_cnt[n] == ERR_MAX && !cnt_clr[n] |=> err_cnt[n] == ERR_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("error count left saturation"); // RULE_10

    property p_clear;
      @(posedge i_clk) disable iff (i_sys_rst)
      cnt_clr[n] && inc == 4'h0 |=> err_cnt[n] == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("error count not cleared"); // RULE_06

    property p_window;
      @(posedge i_clk) disable iff (i_sys_rst)
      !(chk_hit && r1.stream == 5'(n)) && !cnt_clr[n] |=> $stable(err_cnt[n]);
    endproperty
    a_window: assert property (p_window) else $error("count moved outside window"); // RULE_23
  end

  // ********************
  // host read
  // ********************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata    <= 16'h0000;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_cs && i_rd;
      if (i_addr == ADDR_MODE) begin
        o_rdata <= 16'((chk_grp_en << MODE_CHK_BIT) | (gen_grp_en << MODE_GEN_BIT));
      end else if (i_addr[13:SW] == ADDR_CTRL_BASE[13:SW]) begin
        o_rdata <= {15'h0000, chk_en[idx]};
      end else if (i_addr[13:SW] == ADDR_START_BASE[13:SW]) begin
        o_rdata <= {8'h00, start_ch[idx]};
      end else if (i_addr[13:SW] == ADDR_LEN_BASE[13:SW]) begin
        o_rdata <= {7'h00, len_ch[idx]};
      end else if (i_addr[13:SW] == ADDR_ERR_BASE[13:SW]) begin
        o_rdata <= err_cnt[idx];
      end else if (i_addr[13:SW] == ADDR_QUAD_BASE[13:SW]) begin
        o_rdata <= {4'h0, qforce[idx]};
      end else begin
        o_rdata <= 16'h0000;
      end
    end
  end

  // ********************
  // input side: forcing, then checker
  // ********************
  logic [1:0] quad;
  logic [2:0] code;
  rx_chan_t   rx_f;

  always_comb begin
    // RULE_19 quadrant from channel and rate
    quad = 2'(i_rx.chan >> (QUAD_SHIFT + 32'(i_rx.rate)));
    code = qforce[i_rx.stream][quad*QF_W +: QF_W];
    rx_f = i_rx;
    // RULE_21 force lsb or msb
    if (code[QF_EN] && code[QF_MSB]) rx_f.data[7] = code[QF_VAL];
    if (code[QF_EN] && !code[QF_MSB]) rx_f.data[0] = code[QF_VAL];
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      r1_valid   <= 1'b0;
      r1         <= '0;
      r1_code    <= 3'h0;
      o_rx_valid <= 1'b0;
      o_rx_byte  <= 8'h00;
    end else begin
      r1_valid   <= i_rx_valid;
      r1         <= rx_f;
      r1_code    <= code;
      o_rx_valid <= i_rx_valid;
      o_rx_byte  <= rx_f.data;
    end
  end

  // memory holds stale state until a stream is first used
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_init <= '0;
    end else if (chk_hit) begin
      rx_init[r1.stream] <= 1'b1;
    end
  end

  // RULE_01 one checker history per stream
  stream_ram #(.W(PRBS_LEN), .D(N)) u_rx_ram (
    .i_clk   (i_clk),
    .i_we    (chk_hit),
    .i_waddr (r1.stream),
    .i_wdata (rx_res[14:0]),
    .i_raddr (i_rx.stream),
    .o_rdata (rx_rdata)
  );

  // ********************
  // output side: generator and translation
  // ********************
  tx_chan_t    t1;
  logic        t1_valid;
  logic        pat;
  logic        tx_we;
  logic [14:0] tx_rdata;
  logic [26:0] tx_res;
  logic [7:0]  xl_byte;
  logic [N-1:0] tx_init;

  // RULE_02 sequence from generator state
  assign tx_res = prbs8(tx_init[t1.stream] ? tx_rdata : PRBS_SEED, 8'h00, 1'b1);
  // RULE_03 any channel marked carries pattern
  assign pat    = t1.message_mode_bit && t1.per_channel_control == PCC_PATTERN && gen_grp_en;
  assign tx_we  = t1_valid && pat;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      t1_valid   <= 1'b0;
      t1         <= '0;
      o_tx_valid <= 1'b0;
      o_tx_byte  <= 8'h00;
    end else begin
      t1_valid   <= i_tx_valid;
      t1         <= i_tx;
      o_tx_valid <= t1_valid;
      o_tx_byte  <= pat ? tx_res[26:19] : xl_byte;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_init <= '0;
    end else if (tx_we) begin
      tx_init[t1.stream] <= 1'b1;
    end
  end

  stream_ram #(.W(PRBS_LEN), .D(N)) u_tx_ram (
    .i_clk   (i_clk),
    .i_we    (tx_we),
    .i_waddr (t1.stream),
    .i_wdata (tx_res[14:0]),
    .i_raddr (i_tx.stream),
    .o_rdata (tx_rdata)
  );

  // RULE_13 same path for switched and message data
  // RULE_14 fields from the high connection word
  law_xlate u_xlate (
    .i_data_class (t1.data_class),
    .i_in_law     (t1.input_law_select),
    .i_out_law    (t1.output_law_select),
    .i_data       (t1.data),
    .o_data       (xl_byte)
  );

  // ********************
  // assertions
  // ********************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  property p_grp_reset;
    $past(i_sys_rst) |-> !chk_grp_en && !gen_grp_en;
  endproperty
  a_grp_reset: assert property (p_grp_reset) else $error("group enable set after reset"); // RULE_04

  property p_gen_off;
    t1_valid && !gen_grp_en && t1.data_class && t1.input_law_select == t1.output_law_select
      |=> o_tx_byte == $past(t1.data);
  endproperty
  a_gen_off: assert property (p_gen_off) else $error("generator ran while off"); // RULE_04

  property p_lsb_force;
    o_rx_valid && r1_code[QF_EN] && !r1_code[QF_MSB] |-> o_rx_byte[0] == r1_code[QF_VAL];
  endproperty
  a_lsb_force: assert property (p_lsb_force) else $error("lsb not forced"); // RULE_21

  property p_msb_force;
    o_rx_valid && r1_code[QF_EN] && r1_code[QF_MSB] |-> o_rx_byte[7] == r1_code[QF_VAL];
  endproperty
  a_msb_force: assert property (p_msb_force) else $error("msb not forced"); // RULE_21

  property p_pass;
    t1_valid && !pat && t1.input_law_select == t1.output_law_select
      |=> o_tx_valid && o_tx_byte == $past(t1.data);
  endproperty
  a_pass: assert property (p_pass) else $error("equal laws altered byte"); // RULE_18

  property p_data_all;
    t1_valid && !pat && t1.data_class && t1.input_law_select == LAW_A
      && t1.output_law_select == LAW_MU_RAW |=> o_tx_byte == ($past(t1.data) ^ ALL_MASK);
  endproperty
  a_data_all: assert property (p_data_all) else $error("data inversion wrong"); // RULE_17

  property p_mu_raw;
    t1_valid && !pat && !t1.data_class && t1.input_law_select == LAW_MU
      && t1.output_law_select == LAW_MU_RAW |=> o_tx_byte == ($past(t1.data) ^ MAG_MASK);
  endproperty
  a_mu_raw: assert property (p_mu_raw) else $error("mu variant magnitude wrong"); // RULE_16

  property p_tx_lat;
    i_tx_valid |-> ##2 o_tx_valid;
  endproperty
  a_tx_lat: assert property (p_tx_lat) else $error("output byte latency wrong"); // RULE_13
endmodule

// File: tdm_xlate_pkg.sv
// shared constants, register map and carrier types for the stream test block
// assumes a 16-bit synchronous host port and byte-wide channel carriers
package tdm_xlate_pkg;
  // ********************
  // sizes
  // ********************
  localparam int NUM_STREAMS = 32;
  localparam int PRBS_LEN    = 15;
  localparam int ERR_W       = 16;
  localparam int QF_W        = 3;
  localparam int QUAD_SHIFT  = 3;
  // ********************
  // register map (word addresses)
  // ********************
  localparam logic [13:0] ADDR_MODE       = 14'h0001;
  localparam logic [13:0] ADDR_QUAD_BASE  = 14'h0120;
  localparam logic [13:0] ADDR_CTRL_BASE  = 14'h0300;
  localparam logic [13:0] ADDR_START_BASE = 14'h0320;
  localparam logic [13:0] ADDR_LEN_BASE   = 14'h0340;
  localparam logic [13:0] ADDR_ERR_BASE   = 14'h0360;
  localparam int MODE_CHK_BIT = 5;
  localparam int MODE_GEN_BIT = 4;
  localparam int CTRL_CLR_BIT = 1;
  localparam int CTRL_EN_BIT  = 0;
  localparam int QF_EN  = 2;
  localparam int QF_MSB = 1;
  localparam int QF_VAL = 0;
  // ********************
  // values
  // ********************
  localparam logic [1:0]  PCC_PATTERN = 2'h2;
  localparam logic [15:0] ERR_MAX     = 16'hffff;
  localparam logic [14:0] PRBS_SEED   = 15'h7fff;
  localparam logic [1:0]  LAW_A       = 2'h0;
  localparam logic [1:0]  LAW_MU      = 2'h1;
  localparam logic [1:0]  LAW_A_RAW   = 2'h2;
  localparam logic [1:0]  LAW_MU_RAW  = 2'h3;
  localparam logic [7:0]  EVEN_MASK   = 8'h55;
  localparam logic [7:0]  ODD_MASK    = 8'haa;
  localparam logic [7:0]  ALL_MASK    = 8'hff;
  localparam logic [7:0]  SIGN_MASK   = 8'h80;
  localparam logic [7:0]  MAG_MASK    = 8'h7f;
  localparam logic [15:0] MU_BIAS     = 16'h0084;
  localparam logic [15:0] MU_CLIP     = 16'h1fdf;
  localparam logic [15:0] MU_ADD      = 16'h0021;
  localparam logic [15:0] MU_TOP      = 16'h1fff;
  localparam logic [15:0] A_BIAS0     = 16'h0008;
  localparam logic [15:0] A_BIAS1     = 16'h0108;
  // ********************
  // carriers
  // ********************
  typedef struct packed {
    logic [4:0] stream;
    logic [7:0] chan;
    logic [1:0] rate;
    logic [7:0] data;
  } rx_chan_t;
  typedef struct packed {
    logic [4:0] stream;
    logic       message_mode_bit;
    logic [1:0] per_channel_control;
    logic       data_class;
    logic [1:0] input_law_select;
    logic [1:0] output_law_select;
    logic [7:0] data;
  } tx_chan_t;
endpackage

// File: stream_ram.sv
// small per-stream state memory, registered read, write-first
// assumes one write and one read per clock
`timescale 1ns/10ps
module stream_ram #(
  parameter int W = 15,
  parameter int D = 32
) (
  // clock
  input  wire logic                 i_clk,
  // write side
  input  wire logic                 i_we,
  input  wire logic [$clog2(D)-1:0] i_waddr,
  input  wire logic [W-1:0]         i_wdata,
  // read side
  input  wire logic [$clog2(D)-1:0] i_raddr,
  output logic      [W-1:0]         o_rdata
);
  logic [W-1:0] mem [D];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // forwarding lets the same stream come back to back
  always_ff @(posedge i_clk) begin
    if (i_we && i_waddr == i_raddr) begin
      o_rdata <= i_wdata;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule

// File: law_xlate.sv
// per-channel coding law translation, combinational
// assumes law codes and class bit come from the high connection word
`timescale 1ns/10ps
module law_xlate (
  // selection
  input  wire logic       i_data_class,
  input  wire logic [1:0] i_in_law,
  input  wire logic [1:0] i_out_law,
  // byte
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data
);
  import tdm_xlate_pkg::*;

  function automatic logic [7:0] data_mask(input logic [1:0] c);
    case (c)
      2'h0:    data_mask = 8'h00;
      2'h1:    data_mask = EVEN_MASK;
      2'h2:    data_mask = ODD_MASK;
      default: data_mask = ALL_MASK;
    endcase
  endfunction

  // canonical form: a-law with even bits restored, mu-law fully restored
  function automatic logic [7:0] canon(input logic [1:0] law, input logic [7:0] c);
    case (law)
      LAW_A:   canon = c ^ EVEN_MASK;
      LAW_MU:  canon = ~c;
      // RULE_16 magnitude left as sent
      LAW_MU_RAW: canon = c ^ SIGN_MASK;
      default: canon = c;
    endcase
  endfunction

  function automatic logic [7:0] mu_enc(input logic neg, input logic [15:0] mag);
    logic [15:0] p;
    logic [2:0]  seg;
    p = {2'h0, mag[15:2]};
    if (p > MU_CLIP) p = MU_CLIP;
    p = p + MU_ADD;
    if (p > MU_TOP) p = MU_TOP;
    seg = 3'h0;
    for (int i = 6; i < 13; i++) if (p[i]) seg = 3'(i - 5);
    mu_enc = {neg, seg, 4'(p >> (4'(seg) + 4'h1))};
  endfunction

  function automatic logic [7:0] a_enc(input logic neg, input logic [15:0] mag);
    logic [15:0] p;
    logic [2:0]  seg;
    p = {3'h0, mag[15:3]};
    seg = 3'h0;
    for (int i = 5; i < 12; i++) if (p[i]) seg = 3'(i - 4);
    a_enc = {~neg, seg, (seg < 3'h2) ? p[4:1] : 4'(p >> seg)};
  endfunction

  logic [7:0]  c_in;
  logic        neg;
  logic [15:0] mag;

  // ********************
  // translation
  // ********************
  always_comb begin
    c_in = canon(i_in_law, i_data);
    neg  = i_in_law[0] ? c_in[7] : ~c_in[7];
    if (i_in_law[0]) begin
      mag = ((16'({c_in[3:0], 3'h0}) + MU_BIAS) << c_in[6:4]) - MU_BIAS;
    end else if (c_in[6:4] == 3'h0) begin
      mag = 16'({c_in[3:0], 4'h0}) + A_BIAS0;
    end else begin
      mag = (16'({c_in[3:0], 4'h0}) + A_BIAS1) << (c_in[6:4] - 3'h1);
    end
    // RULE_17 data class masks
    if (i_data_class) begin
      o_data = i_data ^ data_mask(i_in_law) ^ data_mask(i_out_law);
    // RULE_18 equal laws pass
    end else if (i_in_law == i_out_law) begin
      o_data = i_data;
    // RULE_15 convert via linear
    end else if (i_out_law[0]) begin
      o_data = canon(i_out_law, mu_enc(neg, mag));
    end else begin
      o_data = canon(i_out_law, a_enc(neg, mag));
    end
  end
endmodule

// File: tdm_loopback.sv
// far-end stream model: loops output channels back onto the input side
// assumes the bench sets its controls on the falling edge of i_clk
`timescale 1ns/10ps
module tdm_loopback (
  // clock and control
  input  wire logic                    i_clk,
  input  wire logic                    i_restart,
  input  wire logic [4:0]              i_stream,
  input  wire logic [1:0]              i_rate,
  input  wire logic [7:0]              i_err_mask,
  // direct channel from the bench
  input  wire logic                    i_inj_valid,
  input  wire tdm_xlate_pkg::rx_chan_t i_inj,
  // looped output channel
  input  wire logic                    i_tx_valid,
  input  wire logic [7:0]              i_tx_byte,
  // toward the block
  output logic                         o_rx_valid,
  output tdm_xlate_pkg::rx_chan_t      o_rx
);
  import tdm_xlate_pkg::*;
  logic       lp_valid = 1'b0;
  rx_chan_t   lp       = '0;
  logic [7:0] chan     = 8'h00;
  always @(posedge i_clk) begin
    lp_valid <= i_tx_valid;
    if (i_tx_valid) begin
      lp   <= '{i_stream, chan, i_rate, i_tx_byte ^ i_err_mask};
      chan <= (chan == 8'((32 << i_rate) - 1)) ? 8'h00 : chan + 8'h01;
    end else begin
      // idle line toggles, no stale byte
      lp.data <= ~lp.data;
    end
    if (i_restart) begin
      chan <= 8'h00;
    end
  end
  assign o_rx_valid = i_inj_valid | lp_valid;
  assign o_rx       = i_inj_valid ? i_inj : lp;
endmodule

// File: tdm_stream_test_tb.sv
// self-checking bench for stream test, law translation and quadrant forcing
// assumes the loopback model closes output channels back onto the input side
`timescale 1ns/10ps
module tdm_stream_test_tb;
  import tdm_xlate_pkg::*;
  localparam logic [13:0] CTRL3 = ADDR_CTRL_BASE + 14'h3;
  localparam logic [13:0] ERR3  = ADDR_ERR_BASE + 14'h3;
  logic        i_clk, i_sys_rst, i_cs, i_wr, i_rd, o_rd_valid;
  logic [13:0] i_addr;
  logic [15:0] i_wdata, o_rdata;
  logic        rx_valid, o_rx_valid, i_tx_valid, o_tx_valid;
  rx_chan_t    rx, inj;
  tx_chan_t    i_tx;
  logic [7:0]  o_rx_byte, o_tx_byte, err_mask;
  logic        restart, inj_valid, prbs_on;
  logic [4:0]  lb_stream;
  logic [1:0]  lb_rate;
  logic [1:0]  mk;
  logic [14:0] hist;
  int          nb, ones, prbs_bad, cycles, fail_count, n_tests;

  tdm_stream_test tdm_stream_test_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cs(i_cs), .i_wr(i_wr), .i_rd(i_rd),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
    .i_rx_valid(rx_valid), .i_rx(rx), .o_rx_valid(o_rx_valid), .o_rx_byte(o_rx_byte),
    .i_tx_valid(i_tx_valid), .i_tx(i_tx), .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte)
  );
  tdm_loopback tdm_loopback_inst (
    .i_clk(i_clk), .i_restart(restart), .i_stream(lb_stream), .i_rate(lb_rate),
    .i_err_mask(err_mask), .i_inj_valid(inj_valid), .i_inj(inj),
    .i_tx_valid(o_tx_valid), .i_tx_byte(o_tx_byte), .o_rx_valid(rx_valid), .o_rx(rx)
  );

  // ********************
  // clock, timeout, pattern monitor
  // ********************
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    mk     <= {mk[0], i_tx_valid & i_tx.message_mode_bit
               & (i_tx.per_channel_control == PCC_PATTERN)};
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  always @(negedge i_clk) begin
    if (prbs_on && mk[1] && o_tx_valid) begin
      for (int b = 7; b >= 0; b--) begin
        if (nb >= 15 && o_tx_byte[b] !== (hist[13] ^ hist[14])) prbs_bad++;
        ones += o_tx_byte[b];
        hist = {hist[13:0], o_tx_byte[b]};
        nb++;
      end
    end
  end

  // ********************
  // shared tasks
  // ********************
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    @(negedge i_clk);
    {i_cs, i_wr, i_addr, i_wdata} = {2'b11, a, d};
    @(negedge i_clk);
    {i_cs, i_wr} = 2'b00;
  endtask
  task automatic rd(input logic [13:0] a, input logic [15:0] exp);
    @(negedge i_clk);
    {i_cs, i_rd, i_addr} = {2'b11, a};
    @(negedge i_clk);
    {i_cs, i_rd} = 2'b00;
    cmp("read valid", 16'h0001, {15'h0, o_rd_valid});
    cmp("read data", exp, o_rdata);
  endtask
  task automatic reg_rw(input logic [13:0] a, input logic [15:0] exp);
    rd(a, 16'h0000);
    wr(a, 16'hffff);
    rd(a, exp);
  endtask
  task automatic tx_chk(input tx_chan_t t, input logic [7:0] exp);
    @(negedge i_clk);
    {i_tx_valid, i_tx} = {1'b1, t};
    @(negedge i_clk);
    i_tx_valid = 1'b0;
    @(negedge i_clk);
    cmp("tx valid", 16'h0001, {15'h0, o_tx_valid});
    cmp("tx byte", {8'h00, exp}, {8'h00, o_tx_byte});
  endtask
  task automatic rx_chk(input logic [7:0] ch, input logic [1:0] r, input logic [7:0] d,
                        input logic [7:0] e);
    @(negedge i_clk);
    {inj_valid, inj} = {1'b1, 5'd5, ch, r, d};
    @(negedge i_clk);
    inj_valid = 1'b0;
    cmp("rx valid", 16'h0001, {15'h0, o_rx_valid});
    cmp("rx byte", {8'h00, e}, {8'h00, o_rx_byte});
  endtask
  // frames of looped channels, pattern only inside the window
  task automatic run(input int st, input int len, input int nf);
    for (int f = 0; f < nf * (32 << lb_rate); f++) begin
      @(negedge i_clk);
      i_tx_valid = 1'b1;
      i_tx = '0;
      i_tx.stream = lb_stream;
      if (f % (32 << lb_rate) >= st && f % (32 << lb_rate) < st + len) begin
        i_tx.message_mode_bit = 1'b1;
        i_tx.per_channel_control = PCC_PATTERN;
      end
    end
    @(negedge i_clk);
    i_tx_valid = 1'b0;
    repeat (8) @(negedge i_clk);
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic test_regs();
    reg_rw(ADDR_MODE, 16'h0030);
    reg_rw(ADDR_QUAD_BASE + 14'h1f, 16'h0fff);
    reg_rw(ADDR_CTRL_BASE + 14'h1f, 16'h0001);
    reg_rw(ADDR_START_BASE + 14'h1f, 16'h00ff);
    reg_rw(ADDR_LEN_BASE + 14'h1f, 16'h01ff);
    reg_rw(ADDR_ERR_BASE + 14'h1f, 16'h0000);
    reg_rw(14'h3fff, 16'h0000);
  endtask
  task automatic test_law();
    tx_chan_t   t;
    logic [7:0] m [4] = '{8'h00, EVEN_MASK, ODD_MASK, ALL_MASK};
    logic [11:0] v [8] = '{12'h000, 12'h500, 12'ha00, 12'hf00,
                           12'h255, 12'h855, 12'h77f, 12'hd7f};
    wr(ADDR_MODE, 16'h0000);
    t = '0;
    t.message_mode_bit = 1'b1;
    t.per_channel_control = PCC_PATTERN;
    t.data_class = 1'b1;
    t.data = 8'ha5;
    tx_chk(t, 8'ha5);
    t.per_channel_control = 2'h0;
    for (int i = 0; i < 16; i++) begin
      t.message_mode_bit = i[0];
      {t.input_law_select, t.output_law_select} = 4'(i);
      t.data = 8'h3c + 8'(i);
      tx_chk(t, t.data ^ m[i / 4] ^ m[i % 4]);
    end
    t.data_class = 1'b0;
    t.data = 8'h96;
    for (int i = 0; i < 8; i++) begin
      {t.input_law_select, t.output_law_select} = v[i][11:8];
      tx_chk(t, 8'h96 ^ v[i][7:0]);
    end
  endtask
  task automatic test_quad();
    logic [7:0] ch, d, e;
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_QUAD_BASE + 14'h5, p ? 16'h06db : 16'h0fac);
      for (int r = 0; r < 4; r++) begin
        for (int q = 0; q < 8; q++) begin
          ch = 8'((q / 2) * (8 << r) + (q % 2) * ((8 << r) - 1));
          d  = (q % 2) ? 8'h81 : 8'h7e;
          e  = d;
          if (p == 0 && q > 3) e[7] = q[1];
          if (p == 0 && q < 4) e[0] = q[1];
          rx_chk(ch, 2'(r), d, e);
        end
      end
    end
  endtask
  task automatic test_ber();
    lb_stream = 5'd3;
    restart   = 1'b1;
    wr(ADDR_MODE, 16'h0030);
    restart   = 1'b0;
    wr(ADDR_START_BASE + 14'h3, 16'h000a);
    wr(ADDR_LEN_BASE + 14'h3, 16'h0004);
    prbs_on = 1'b1;
    run(10, 4, 2);
    wr(CTRL3, 16'h0001);
    run(10, 4, 2);
    wr(CTRL3, 16'h0003);
    run(10, 4, 4);
    prbs_on = 1'b0;
    cmp("pattern taps", 16'h0000, prbs_bad[15:0]);
    cmp("pattern live", 16'h0001, {15'h0, ones > 0});
    rd(ERR3, 16'h0000);
    // one flipped bit per byte: three miscompares per window byte
    err_mask = 8'h01;
    run(10, 4, 2);
    wr(CTRL3, 16'h0003);
    run(10, 4, 4);
    rd(ERR3, 16'd48);
    wr(CTRL3, 16'h0002);
    run(10, 4, 2);
    rd(ERR3, 16'h0000);
    wr(ADDR_MODE, 16'h0010);
    wr(CTRL3, 16'h0001);
    run(10, 4, 2);
    rd(ERR3, 16'h0000);
    // full frame at top rate, every bit wrong
    wr(ADDR_MODE, 16'h0030);
    lb_rate = 2'd3;
    err_mask = 8'hff;
    wr(ADDR_START_BASE + 14'h3, 16'h0000);
    wr(ADDR_LEN_BASE + 14'h3, 16'h0100);
    run(0, 256, 34);
    rd(ERR3, ERR_MAX);
    run(0, 256, 2);
    rd(ERR3, ERR_MAX);
  endtask

  initial begin
    {i_cs, i_wr, i_rd, i_tx_valid, restart, inj_valid, prbs_on} = '0;
    {i_addr, i_wdata, i_tx, inj, err_mask, lb_stream, lb_rate, hist, mk} = '0;
    {nb, ones, prbs_bad, cycles, fail_count, n_tests} = '0;
    i_sys_rst = 1'b1;
    repeat (20) @(negedge i_clk);
    i_sys_rst = 1'b0;
    test_regs();
    test_law();
    test_quad();
    test_ber();
    end_of_test();
  end
endmodule
